// File: t8wg_timer.sv
// t8wg_timer: 8-bit timer/counter with compare unit and waveform generator
// assumes: Avalon-MM master on ref_clk, port driver outside uses pin/oe pair
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
module t8wg_timer (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic external_count_pin,
   input wire logic compare_vector_ack,
   input wire logic overflow_vector_ack,
   output logic compare_output_pin_o,
   output logic compare_output_pin_oe,
   output logic compare_flag,
   output logic overflow_flag
);

   ////////////////////////////////////////////////////////////////////////////
   // reset release

   logic [1:0] rst_sync_reg;
   logic rst_n_sync;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n_sync = rst_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////////
   // state

   t8wg_pkg::t8wg_ctrl_t ctrl_reg;
   t8wg_pkg::t8wg_ctrl_t ctrl_wr;
   t8wg_pkg::t8wg_mode_t mode;
   logic [7:0] count_value_reg;
   logic [7:0] compare_value_reg;
   logic [7:0] compare_act_reg;
   logic dir_down_reg;
   logic block_reg;
   logic compare_output_reg;
   logic compare_output_next;
   logic cmp_flag_reg;
   logic ovf_flag_reg;
   logic port_val_reg;
   logic port_dir_reg;
   logic pin_o_reg;
   logic pin_oe_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic [7:0] rd_byte;
   logic timer_tick_enable;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave: one wait cycle, then the request is taken

   logic req;
   logic take;
   logic wr_en;
   logic wr_ctrl;
   logic wr_count;
   logic wr_compare;
   logic wr_flags;
   logic wr_port;

   assign req = avs_read | avs_write;
   assign take = req & ~wait_reg;
   assign wr_en = take & avs_write & avs_byteenable[0];
   assign wr_ctrl = wr_en & (avs_address == t8wg_pkg::OFS_CONTROL);
   assign wr_count = wr_en & (avs_address == t8wg_pkg::OFS_COUNT);
   assign wr_compare = wr_en & (avs_address == t8wg_pkg::OFS_COMPARE);
   assign wr_flags = wr_en & (avs_address == t8wg_pkg::OFS_FLAGS);
   assign wr_port = wr_en & (avs_address == t8wg_pkg::OFS_PORT);
   assign ctrl_wr = t8wg_pkg::t8wg_ctrl_t'(avs_writedata[7:0]);

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         wait_reg <= 1'b1;
      end else if (take) begin
         wait_reg <= 1'b1;
      end else if (req) begin
         wait_reg <= 1'b0;
      end
   end

   always_comb begin
      rd_byte = 8'h00;
      unique case (avs_address)
         t8wg_pkg::OFS_CONTROL: begin
            rd_byte = ctrl_reg;
            rd_byte[7] = 1'b0;
         end
         t8wg_pkg::OFS_COUNT: rd_byte = count_value_reg;
         t8wg_pkg::OFS_COMPARE: rd_byte = compare_value_reg;
         t8wg_pkg::OFS_FLAGS: begin
            rd_byte[t8wg_pkg::FLAG_OVF_BIT] = ovf_flag_reg;
            rd_byte[t8wg_pkg::FLAG_CMP_BIT] = cmp_flag_reg;
         end
         t8wg_pkg::OFS_PORT: begin
            rd_byte[t8wg_pkg::PORT_VAL_BIT] = port_val_reg;
            rd_byte[t8wg_pkg::PORT_DIR_BIT] = port_dir_reg;
         end
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         rdata_reg <= 32'h0000_0000;
      end else if (avs_read & wait_reg) begin
         rdata_reg <= {24'h00_0000, rd_byte};
      end
   end

   assign avs_waitrequest = wait_reg;
   assign avs_readdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // control and port registers

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         ctrl_reg <= t8wg_pkg::CONTROL_RST;
      end else if (wr_ctrl) begin
         ctrl_reg <= ctrl_wr;
         ctrl_reg.force_compare_strobe <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         port_val_reg <= 1'b0;
         port_dir_reg <= 1'b0;
      end else if (wr_port) begin
         port_val_reg <= avs_writedata[t8wg_pkg::PORT_VAL_BIT];
         port_dir_reg <= avs_writedata[t8wg_pkg::PORT_DIR_BIT];
      end
   end

   assign mode = t8wg_pkg::t8wg_mode_t'({ctrl_reg.mode_hi, ctrl_reg.mode_lo});

   t8wg_tick u_tick (
      .ref_clk(ref_clk),
      .rst_n_sync(rst_n_sync),
      .clock_select_field(ctrl_reg.clock_select_field),
      .external_count_pin(external_count_pin),
      .timer_tick_enable(timer_tick_enable)
   );

   ////////////////////////////////////////////////////////////////////////////
   // compare decode

   logic at_max;
   logic at_bottom;
   logic at_top;
   logic cmp_is_top;
   logic step;
   logic match;
   logic force_hit;
   logic [1:0] act;

   assign at_max = count_value_reg == t8wg_pkg::MAX;
   assign at_bottom = count_value_reg == t8wg_pkg::BOTTOM;
   assign at_top = (mode == t8wg_pkg::MODE_CTC) ? (count_value_reg == compare_act_reg) : at_max;
   assign cmp_is_top = compare_act_reg == t8wg_pkg::MAX;
   assign step = timer_tick_enable & ~wr_count;
   assign match = step & ~block_reg & (count_value_reg == compare_act_reg);
   assign force_hit = wr_ctrl & ctrl_wr.force_compare_strobe & ~ctrl_wr.mode_lo;
   assign act = ctrl_reg.output_action_field;

   ////////////////////////////////////////////////////////////////////////////
   // counter

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         count_value_reg <= t8wg_pkg::COUNT_RST;
         dir_down_reg <= 1'b0;
      end else if (wr_count) begin
         count_value_reg <= avs_writedata[7:0];
      end else if (timer_tick_enable) begin
         unique case (mode)
            t8wg_pkg::MODE_PHASE: begin
               // 255 up steps and 255 down steps make 510 ticks
               if (!dir_down_reg) begin
                  if (at_max) begin
                     count_value_reg <= count_value_reg - t8wg_pkg::ONE;
                     dir_down_reg <= 1'b1;
                  end else begin
                     count_value_reg <= count_value_reg + t8wg_pkg::ONE;
                  end
               end else if (at_bottom) begin
                  count_value_reg <= count_value_reg + t8wg_pkg::ONE;
                  dir_down_reg <= 1'b0;
               end else begin
                  count_value_reg <= count_value_reg - t8wg_pkg::ONE;
               end
            end
            t8wg_pkg::MODE_CTC: begin
               dir_down_reg <= 1'b0;
               if (at_top) begin
                  count_value_reg <= t8wg_pkg::BOTTOM;
               end else begin
                  count_value_reg <= count_value_reg + t8wg_pkg::ONE;
               end
            end
            t8wg_pkg::MODE_NORMAL, t8wg_pkg::MODE_FAST: begin
               dir_down_reg <= 1'b0;
               count_value_reg <= count_value_reg + t8wg_pkg::ONE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         block_reg <= 1'b0;
      end else if (wr_count) begin
         block_reg <= 1'b1;
      end else if (timer_tick_enable) begin
         block_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // compare value and its double buffer

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         compare_value_reg <= t8wg_pkg::COMPARE_RST;
      end else if (wr_compare) begin
         compare_value_reg <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         compare_act_reg <= t8wg_pkg::COMPARE_RST;
      end else begin
         unique case (mode)
            t8wg_pkg::MODE_NORMAL, t8wg_pkg::MODE_CTC: begin
               compare_act_reg <= compare_value_reg;
            end
            t8wg_pkg::MODE_PHASE: begin
               if (step & at_max & ~dir_down_reg) begin
                  compare_act_reg <= compare_value_reg;
               end
            end
            t8wg_pkg::MODE_FAST: begin
               if (step & at_max) begin
                  compare_act_reg <= compare_value_reg;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flags: a set in the same cycle as a clear wins

   logic ovf_set;
   logic cmp_clr;
   logic ovf_clr;

   assign ovf_set = step & ((mode == t8wg_pkg::MODE_PHASE) ? (at_bottom & dir_down_reg) : at_max);
   assign cmp_clr = (wr_flags & avs_writedata[t8wg_pkg::FLAG_CMP_BIT]) | compare_vector_ack;
   assign ovf_clr = (wr_flags & avs_writedata[t8wg_pkg::FLAG_OVF_BIT]) | overflow_vector_ack;

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         cmp_flag_reg <= 1'b0;
      end else if (match) begin
         cmp_flag_reg <= 1'b1;
      end else if (cmp_clr) begin
         cmp_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         ovf_flag_reg <= 1'b0;
      end else if (ovf_set) begin
         ovf_flag_reg <= 1'b1;
      end else if (ovf_clr) begin
         ovf_flag_reg <= 1'b0;
      end
   end

   assign compare_flag = cmp_flag_reg;
   assign overflow_flag = ovf_flag_reg;

   ////////////////////////////////////////////////////////////////////////////
   // waveform generator

   function automatic logic t8wg_apply(input logic [1:0] a, input logic cur);
      logic res;
      res = cur;
      unique case (a)
         t8wg_pkg::ACT_OFF: res = cur;
         t8wg_pkg::ACT_TOGGLE: res = ~cur;
         t8wg_pkg::ACT_CLEAR: res = 1'b0;
         t8wg_pkg::ACT_SET: res = 1'b1;
      endcase
      return res;
   endfunction

   always_comb begin
      compare_output_next = compare_output_reg;
      if (force_hit) begin
         compare_output_next = t8wg_apply(ctrl_wr.output_action_field, compare_output_reg);
      end else if (step) begin
         unique case (mode)
            t8wg_pkg::MODE_NORMAL, t8wg_pkg::MODE_CTC: begin
               if (match) begin
                  compare_output_next = t8wg_apply(act, compare_output_reg);
               end
            end
            t8wg_pkg::MODE_FAST: begin
               // action 1 is reserved and leaves the output alone
               if (act[1]) begin
                  if (at_max) begin
                     compare_output_next = ~act[0];
                  end else if (match & ~cmp_is_top) begin
                     compare_output_next = act[0];
                  end
               end
            end
            t8wg_pkg::MODE_PHASE: begin
               if (act[1]) begin
                  if (at_max & ~dir_down_reg) begin
                     // top action for compare at TOP, else the up-match level
                     compare_output_next = cmp_is_top ? ~act[0] : act[0];
                  end else if (match) begin
                     // a match at BOTTOM counts as up-counting
                     compare_output_next = (dir_down_reg & ~at_bottom) ? ~act[0] : act[0];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         compare_output_reg <= 1'b0;
      end else begin
         compare_output_reg <= compare_output_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin override

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         pin_o_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
      end else begin
         pin_o_reg <= (act != t8wg_pkg::ACT_OFF) ? compare_output_reg : port_val_reg;
         pin_oe_reg <= port_dir_reg;
      end
   end

   assign compare_output_pin_o = pin_o_reg;
   assign compare_output_pin_oe = pin_oe_reg;

endmodule

// File: t8wg_pkg.sv
// t8wg_pkg: constants and types for the 8-bit timer with waveform generator
// assumes: byte addresses on a 32-bit Avalon-MM slave, data in the low byte
package t8wg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map (byte addresses)
   localparam logic [4:0] OFS_CONTROL = 5'h00;
   localparam logic [4:0] OFS_COUNT = 5'h04;
   localparam logic [4:0] OFS_COMPARE = 5'h08;
   localparam logic [4:0] OFS_FLAGS = 5'h0c;
   localparam logic [4:0] OFS_PORT = 5'h10;

   // flag and port register fields
   localparam int FLAG_OVF_BIT = 0;
   localparam int FLAG_CMP_BIT = 1;
   localparam int PORT_VAL_BIT = 0;
   localparam int PORT_DIR_BIT = 1;

   // reset values
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] COMPARE_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // counter limits
   localparam logic [7:0] BOTTOM = 8'h00;
   localparam logic [7:0] MAX = 8'hff;
   localparam logic [7:0] ONE = 8'h01;

   // control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic force_compare_strobe;
      logic mode_lo;
      logic [1:0] output_action_field;
      logic mode_hi;
      logic [2:0] clock_select_field;
   } t8wg_ctrl_t;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_PHASE = 2'b01,
      MODE_CTC = 2'b10,
      MODE_FAST = 2'b11
   } t8wg_mode_t;

   // output actions
   localparam logic [1:0] ACT_OFF = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // clock select codes and prescaler taps
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   localparam logic [9:0] MASK_DIV8 = 10'h007;
   localparam logic [9:0] MASK_DIV64 = 10'h03f;
   localparam logic [9:0] MASK_DIV256 = 10'h0ff;
   localparam logic [9:0] MASK_DIV1024 = 10'h3ff;
   localparam logic [9:0] PRESCALE_STEP = 10'h001;

endpackage

// File: t8wg_tick.sv
// t8wg_tick: prescaler and external pin edge detector making the timer tick
// assumes: external_count_pin already synchronous to ref_clk
`timescale 1ns/100ps
module t8wg_tick (
   input wire logic ref_clk,
   input wire logic rst_n_sync,
   input wire logic [2:0] clock_select_field,
   input wire logic external_count_pin,
   output logic timer_tick_enable
);

   logic [9:0] prescale_reg;
   logic ext_prev_reg;
   logic tick_reg;
   logic tick_next;

   ////////////////////////////////////////////////////////////////////////////
   // free-running prescaler
   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         prescale_reg <= '0;
      end else begin
         prescale_reg <= prescale_reg + t8wg_pkg::PRESCALE_STEP;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         ext_prev_reg <= 1'b0;
      end else begin
         ext_prev_reg <= external_count_pin;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // source select; the tick is only an enable, never a clock
   always_comb begin
      unique case (clock_select_field)
         t8wg_pkg::CS_STOP: tick_next = 1'b0;
         t8wg_pkg::CS_DIV1: tick_next = 1'b1;
         t8wg_pkg::CS_DIV8: tick_next = &(prescale_reg | ~t8wg_pkg::MASK_DIV8);
         t8wg_pkg::CS_DIV64: tick_next = &(prescale_reg | ~t8wg_pkg::MASK_DIV64);
         t8wg_pkg::CS_DIV256: tick_next = &(prescale_reg | ~t8wg_pkg::MASK_DIV256);
         t8wg_pkg::CS_DIV1024: tick_next = &(prescale_reg | ~t8wg_pkg::MASK_DIV1024);
         t8wg_pkg::CS_EXT_FALL: tick_next = ext_prev_reg & ~external_count_pin;
         t8wg_pkg::CS_EXT_RISE: tick_next = ~ext_prev_reg & external_count_pin;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= tick_next;
      end
   end

   assign timer_tick_enable = tick_reg;

endmodule

// File: t8wg_timer_sva.sv
// t8wg_timer_sva: port-level assertions for the timer
// assumes: bound into t8wg_timer, a single ref_clk domain
`timescale 1ns/100ps
module t8wg_timer_sva (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic compare_vector_ack,
   input wire logic compare_output_pin_o,
   input wire logic compare_output_pin_oe,
   input wire logic compare_flag,
   input wire logic overflow_flag,
   input wire logic overflow_vector_ack
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic wr;
   logic [9:0] calm;
   logic [7:0] cmp;
   logic [1:0] prt;
   logic [1:0] md;
   t8wg_pkg::t8wg_ctrl_t c;
   logic quiet;
   logic stop;
   assign wr = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign md = {c.mode_hi, c.mode_lo};
   assign quiet = calm > 10'h2bc && c.clock_select_field == t8wg_pkg::CS_DIV1 && c.output_action_field[1];
   assign stop = calm > 10'h003 && c.clock_select_field == t8wg_pkg::CS_STOP;
   ////////////////////////////////////////
   // shadows of written registers, cycles since the last write
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         calm <= 10'h000;
         c <= '0;
         cmp <= 8'h00;
         prt <= 2'h0;
      end else if (wr) begin
         calm <= 10'h000;
         case (avs_address)
            t8wg_pkg::OFS_CONTROL: c <= avs_writedata[7:0];
            t8wg_pkg::OFS_COMPARE: cmp <= avs_writedata[7:0];
            t8wg_pkg::OFS_PORT: prt <= avs_writedata[1:0];
            default: ;
         endcase
      end else if (calm != 10'h3ff) begin
         calm <= calm + 10'h001;
      end
   end
   ////////////////////////////////////////
   sequence s_take;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   property p_answer;
      $rose(avs_read || avs_write) |=> s_take;
   endproperty
   a_answer: assert property (p_answer) else $error("bus answer off");
   property p_strobe_zero;
      avs_read && !avs_waitrequest && avs_address == t8wg_pkg::OFS_CONTROL |-> avs_readdata[31:7] == '0;
   endproperty
   a_strobe_zero: assert property (p_strobe_zero) else $error("strobe reads one");
   property p_pin_port;
      calm > 10'h002 && c.output_action_field == t8wg_pkg::ACT_OFF
         |-> compare_output_pin_o == prt[0] && compare_output_pin_oe == prt[1];
   endproperty
   a_pin_port: assert property (p_pin_port) else $error("pin not port");
   property p_phase_level;
      quiet && md == t8wg_pkg::MODE_PHASE && (cmp == t8wg_pkg::BOTTOM || cmp == t8wg_pkg::MAX)
         |-> compare_output_pin_o == ((cmp == t8wg_pkg::MAX) ^ c.output_action_field[0]);
   endproperty
   a_phase_level: assert property (p_phase_level) else $error("phase extreme level");
   property p_fast_top;
      quiet && md == t8wg_pkg::MODE_FAST && cmp == t8wg_pkg::MAX |-> compare_output_pin_o == !c.output_action_field[0];
   endproperty
   a_fast_top: assert property (p_fast_top) else $error("fast top level");
   property p_ack_clear;
      stop && overflow_vector_ack |=> !overflow_flag;
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("ack kept flag");
   property p_stop_quiet;
      stop |-> !$rose(compare_flag) && !$rose(overflow_flag);
   endproperty
   a_stop_quiet: assert property (p_stop_quiet) else $error("flag while stopped");
   property p_sticky;
      compare_flag && !compare_vector_ack && !(wr && avs_address == t8wg_pkg::OFS_FLAGS && avs_writedata[1])
         |=> compare_flag;
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped");
endmodule
bind t8wg_timer t8wg_timer_sva i_sva (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_readdata, .avs_waitrequest, .compare_vector_ack, .compare_output_pin_o,
   .compare_output_pin_oe, .compare_flag, .overflow_flag, .overflow_vector_ack);

// File: t8wg_pad.sv
// t8wg_pad: port pin driver beyond the compare output
// assumes: pin level and enable come from the timer on ref_clk
`timescale 1ns/100ps
module t8wg_pad (
   input wire logic ref_clk,
   input wire logic pin_o,
   input wire logic pin_oe,
   output logic pad
);
   logic wander = 1'b0;
   // a released pad changes every cycle, so stale drive never passes
   always @(posedge ref_clk) wander <= ~wander;
   assign pad = pin_oe ? pin_o : wander;
endmodule

// File: timer8_waveform_generator_bench.sv
// timer8_waveform_generator_bench: self-checking bench for t8wg_timer
// assumes: checker bound by its own file, pad model t8wg_pad
`timescale 1ns/100ps
module timer8_waveform_generator_bench;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic external_count_pin = 1'b0;
   logic compare_vector_ack = 1'b0;
   logic overflow_vector_ack = 1'b0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, pin_o, pin_oe, cflag, oflag, pad;
   int n_errors = 0;
   int compares = 0;
   logic [7:0] expq[$];
   logic [7:0] r;
   logic [39:0] per [12] = '{40'h01_40_00_0100, 40'h01_40_01_0100, 40'h02_40_00_0800, 40'h61_80_00_01fe,
      40'h62_80_00_0ff0, 40'h79_80_00_0100, 40'h09_09_01_000a, 40'h0b_09_01_0280, 40'h0c_09_01_0a00,
      40'h0d_09_01_2800, 40'h0e_09_01_0014, 40'h0f_09_01_0014};
   logic [23:0] lvl [6] = '{24'h61_00_00, 24'h61_ff_01, 24'h71_00_01, 24'h71_ff_00, 24'h69_ff_01, 24'h79_ff_00};
   logic [15:0] frc [5] = '{16'ha0_00, 16'h90_01, 16'h90_00, 16'hb0_01, 16'he8_01};
   always #5 ref_clk = ~ref_clk;
   // one rising and one falling pin edge every two cycles
   always @(posedge ref_clk) external_count_pin <= ~external_count_pin;
   t8wg_timer i_dut (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .external_count_pin, .compare_vector_ack, .overflow_vector_ack,
      .compare_output_pin_o(pin_o), .compare_output_pin_oe(pin_oe), .compare_flag(cflag), .overflow_flag(oflag));
   t8wg_pad i_pad (.ref_clk, .pin_o, .pin_oe, .pad);
   ////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic bus(input logic rd, input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      avs_read <= rd;
      avs_write <= !rd;
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= 4'h1;
      do @(posedge ref_clk); while (avs_waitrequest);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b0, a, d);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      expq.push_back(e);
      bus(1'b1, a, 8'h00);
   endtask
   // read results are matched against the oldest note
   always @(posedge ref_clk) begin
      if (avs_read && !avs_waitrequest) begin
         check(avs_readdata, {24'h0, expq.pop_front()}, "read");
      end
   end
   task automatic pulse(input logic s);
      @(posedge ref_clk);
      {compare_vector_ack, overflow_vector_ack} <= s ? 2'h2 : 2'h1;
      @(posedge ref_clk);
      {compare_vector_ack, overflow_vector_ack} <= 2'h0;
   endtask
   // ref_clk cycles between flag rises, the first two rises only settle the new mode
   task automatic period(input logic s, input logic [15:0] p);
      int n;
      repeat (3) begin
         pulse(s);
         n = 2;
         do begin
            @(posedge ref_clk);
            #1;
            n++;
         end while ((s ? cflag : oflag) !== 1'b1);
      end
      check(32'(n), {16'h0, p}, "period");
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      r = 8'($urandom(32'hf529deae));
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      for (int a = 0; a < 6; a++) rd(5'(4 * a), 8'h00);
      r = 8'($urandom);
      wr(t8wg_pkg::OFS_COMPARE, r);
      rd(t8wg_pkg::OFS_COMPARE, r);
      wr(t8wg_pkg::OFS_COUNT, ~r);
      rd(t8wg_pkg::OFS_COUNT, ~r);
      wr(5'h14, r);
      rd(5'h14, 8'h00);
      $display("test registers done");
      foreach (per[i]) begin
         wr(t8wg_pkg::OFS_CONTROL, per[i][39:32]);
         wr(t8wg_pkg::OFS_COMPARE, per[i][31:24]);
         period(per[i][16], per[i][15:0]);
      end
      $display("test periods done");
      wr(t8wg_pkg::OFS_PORT, 8'h02);
      foreach (lvl[i]) begin
         wr(t8wg_pkg::OFS_CONTROL, lvl[i][23:16]);
         wr(t8wg_pkg::OFS_COMPARE, lvl[i][15:8]);
         repeat (720) @(posedge ref_clk);
         check(32'(pin_o), 32'(lvl[i][0]), "level");
         check(32'(pad), 32'(pin_o), "pad");
         check(32'(pin_oe), 32'h1, "enable");
      end
      $display("test levels done");
      wr(t8wg_pkg::OFS_CONTROL, 8'h00);
      repeat (4) @(posedge ref_clk);
      pulse(1'b0);
      rd(t8wg_pkg::OFS_FLAGS, 8'h02);
      wr(t8wg_pkg::OFS_FLAGS, 8'h03);
      foreach (frc[i]) begin
         wr(t8wg_pkg::OFS_CONTROL, frc[i][15:8]);
         repeat (4) @(posedge ref_clk);
         check(32'(pin_o), 32'(frc[i][0]), "force");
      end
      rd(t8wg_pkg::OFS_CONTROL, 8'h68);
      rd(t8wg_pkg::OFS_FLAGS, 8'h00);
      $display("test force done");
      finish_test();
   end
   initial begin
      #2000000;
      n_errors++;
      finish_test();
   end
endmodule
